// *** btu_pkg.sv ***
// Purpose: shared constants and types for the bit test unit
// Assumes: 40-bit accumulators, 16-bit aux/temp registers and memory words
// Notes: opcode low nibble codes select the test flag; op_kind alone selects the memory operation
package btu_pkg;
	localparam int ACC_W = 40;
	localparam int WORD_W = 16;
	localparam int ACC_POS_W = 6;
	localparam int WORD_POS_W = 4;
	localparam logic [5:0] ACC_TOP_POS = 6'h27;
	localparam logic [3:0] WORD_TOP_POS = 4'hF;
	// last opcode nibble of the register test
	localparam logic [3:0] NIB_REG_TF1 = 4'h8;
	localparam logic [3:0] NIB_REG_TF2 = 4'h9;
	// bit 0 of the nibble picks the flag in plain memory tests
	localparam int NIB_FLAG_BIT = 0;
	// clear and invert forms carry the flag choice in bit 1
	localparam int NIB_MOD_FLAG_BIT = 1;

	typedef enum logic [2:0] {
		BTU_OP_REG_TEST,
		BTU_OP_PAIR_TEST,
		BTU_OP_MEM_TEST_REG,
		BTU_OP_MEM_TEST_IMM,
		BTU_OP_MEM_CLEAR,
		BTU_OP_MEM_INVERT
	} btu_op_t;

	typedef enum logic {
		BTU_SRC_ACC,
		BTU_SRC_AUX
	} btu_src_t;
endpackage : btu_pkg

// *** btu_reg_alu.sv ***
// Purpose: register-side bit extraction, single and pair
// Assumes: aux/temp operand in low 16 bits of src_val
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none
module btu_reg_alu
	import btu_pkg::*;
(
	input wire btu_pkg::btu_src_t src_kind,
	input wire logic [btu_pkg::ACC_W-1:0] src_val,
	input wire logic [btu_pkg::ACC_POS_W-1:0] pos,
	output logic bit_lo,
	output logic bit_hi,
	output logic pair_lo,
	output logic pair_hi
);
	logic [WORD_POS_W-1:0] wpos;
	assign wpos = pos[WORD_POS_W-1:0];
	// =======================================
	// single and pair extraction
	always_comb
	begin
		bit_lo = 1'b0;
		bit_hi = 1'b0;
		pair_lo = 1'b0;
		pair_hi = 1'b0;
		if (src_kind == BTU_SRC_ACC)
		begin
			// accumulator path, data-unit alu
			if (pos <= ACC_TOP_POS)
				bit_lo = src_val[pos];
			if (pos < ACC_TOP_POS)
			begin
				pair_lo = src_val[pos];
				pair_hi = src_val[pos + 6'h01];
			end
			else if (pos == ACC_TOP_POS)
				pair_lo = src_val[ACC_TOP_POS];
			// others stay zero
		end
		else
		begin
			// aux/temp path, address-unit alu
			bit_lo = src_val[wpos];
			if (wpos != WORD_TOP_POS)
			begin
				pair_lo = src_val[wpos];
				pair_hi = src_val[wpos + 4'h1];
			end
			else
				pair_lo = src_val[WORD_TOP_POS];
		end
	end
endmodule : btu_reg_alu
`default_nettype wire

// *** btu_mem_alu.sv ***
// Purpose: memory-word bit test and modify
// Assumes: one 16-bit word, bit index 0-15
// Notes: combinational; the top sequences the access
`timescale 1ns/1ps
`default_nettype none
module btu_mem_alu
	import btu_pkg::*;
(
	input wire logic [btu_pkg::WORD_W-1:0] word_in,
	input wire logic [btu_pkg::WORD_POS_W-1:0] idx,
	input wire logic do_clear,
	input wire logic do_invert,
	output logic tested,
	output logic [btu_pkg::WORD_W-1:0] word_out
);
	logic [WORD_W-1:0] mask;
	assign mask = WORD_W'(1) << idx;
	assign tested = word_in[idx];
	// =======================================
	// modify only the chosen bit
	always_comb
	begin
		word_out = word_in;
		if (do_clear)
			word_out = word_in & ~mask;
		else if (do_invert)
			word_out = word_in ^ mask;
	end
endmodule : btu_mem_alu
`default_nettype wire

// *** btu_top.sv ***
// Purpose: bit test execution unit of a fixed-point dsp core
// Assumes: memory answers a read in the same cycle as mem_rd_req
// Notes: register tests finish in the issue cycle; memory tests in two, clear and invert in three
`timescale 1ns/1ps
`default_nettype none
module btu_top
	import btu_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic op_valid,
	output logic op_ready,
	input wire btu_pkg::btu_op_t op_kind,
	input wire logic [3:0] op_nibble,
	input wire btu_pkg::btu_src_t src_kind,
	input wire logic [btu_pkg::ACC_W-1:0] src_val,
	input wire logic [btu_pkg::ACC_POS_W-1:0] bit_address_operand,
	input wire logic [3:0] imm_bit_index,
	input wire logic [btu_pkg::WORD_W-1:0] mem_addr,
	output logic mem_rd_req,
	output logic mem_wr_req,
	output logic mem_lock,
	output logic [btu_pkg::WORD_W-1:0] mem_rd_addr,
	output logic [btu_pkg::WORD_W-1:0] mem_wr_data,
	input wire logic [btu_pkg::WORD_W-1:0] mem_rd_data,
	output logic test_flag_one,
	output logic test_flag_two,
	output logic op_done
);
	typedef enum logic [1:0] {
		BTU_IDLE,
		BTU_READ,
		BTU_WRITE
	} btu_state_t;

	btu_state_t state_q;
	btu_op_t kind_q;
	logic flag_sel_q;
	logic [WORD_POS_W-1:0] idx_q;
	logic [WORD_W-1:0] addr_q;
	logic [WORD_W-1:0] wr_data_q;
	logic bit_lo, bit_hi, pair_lo, pair_hi;
	logic tested;
	logic [WORD_W-1:0] mod_word;
	logic issue;
	logic mem_op;
	logic modify_q;

	function automatic logic is_mem_op(input btu_op_t k);
		return k inside {BTU_OP_MEM_TEST_REG, BTU_OP_MEM_TEST_IMM,
			BTU_OP_MEM_CLEAR, BTU_OP_MEM_INVERT};
	endfunction : is_mem_op

	function automatic logic is_modify_op(input btu_op_t k);
		return k inside {BTU_OP_MEM_CLEAR, BTU_OP_MEM_INVERT};
	endfunction : is_modify_op

	// =======================================
	// issue handshake
	// single-cycle issue lets repeat loops re-issue back to back
	assign op_ready = (state_q == BTU_IDLE);
	assign issue = op_valid && op_ready;
	assign mem_op = is_mem_op(op_kind);

	btu_reg_alu u_reg_alu (
		.src_kind(src_kind),
		.src_val(src_val),
		.pos(bit_address_operand),
		.bit_lo(bit_lo),
		.bit_hi(bit_hi),
		.pair_lo(pair_lo),
		.pair_hi(pair_hi)
	);

	btu_mem_alu u_mem_alu (
		.word_in(mem_rd_data),
		.idx(idx_q),
		.do_clear(kind_q == BTU_OP_MEM_CLEAR),
		.do_invert(kind_q == BTU_OP_MEM_INVERT),
		.tested(tested),
		.word_out(mod_word)
	);

	// =======================================
	// memory sequencer
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			state_q <= BTU_IDLE;
		else
		begin
			unique case (state_q)
				BTU_IDLE:
					if (issue && mem_op)
						state_q <= BTU_READ;
				BTU_READ:
					state_q <= modify_q ? BTU_WRITE : BTU_IDLE;
				BTU_WRITE:
					state_q <= BTU_IDLE;
				default:
					state_q <= BTU_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			kind_q <= BTU_OP_REG_TEST;
			flag_sel_q <= 1'b0;
			idx_q <= '0;
			addr_q <= '0;
			modify_q <= 1'b0;
		end
		else if (issue && mem_op)
		begin
			kind_q <= op_kind;
			addr_q <= mem_addr;
			modify_q <= is_modify_op(op_kind);
			// modify forms keep the flag choice one bit higher
			if (is_modify_op(op_kind))
				flag_sel_q <= op_nibble[NIB_MOD_FLAG_BIT];
			else
				flag_sel_q <= op_nibble[NIB_FLAG_BIT];
			if (op_kind == BTU_OP_MEM_TEST_REG)
				idx_q <= src_val[WORD_POS_W-1:0];
			else
				idx_q <= imm_bit_index;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			wr_data_q <= '0;
		else if (state_q == BTU_READ)
			wr_data_q <= mod_word;
	end

	// lock spans read through write-back so nothing slips in between
	assign mem_lock = (state_q == BTU_READ) ||
		(state_q == BTU_WRITE);
	assign mem_rd_req = (state_q == BTU_READ);
	assign mem_wr_req = (state_q == BTU_WRITE);
	assign mem_rd_addr = addr_q;
	assign mem_wr_data = wr_data_q;

	// =======================================
	// test flags
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			test_flag_one <= 1'b0;
			test_flag_two <= 1'b0;
		end
		else if (issue && op_kind == BTU_OP_PAIR_TEST)
		begin
			test_flag_one <= pair_lo;
			test_flag_two <= pair_hi;
		end
		else if (issue && op_kind == BTU_OP_REG_TEST)
		begin
			if (op_nibble == NIB_REG_TF1)
				test_flag_one <= bit_lo;
			else if (op_nibble == NIB_REG_TF2)
				test_flag_two <= bit_lo;
		end
		else if (state_q == BTU_READ)
		begin
			if (flag_sel_q)
				test_flag_two <= tested;
			else
				test_flag_one <= tested;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			op_done <= 1'b0;
		else
			op_done <= (issue && !mem_op) ||
				(state_q == BTU_READ && !modify_q) ||
				(state_q == BTU_WRITE);
	end

	// =======================================
	// checks
	pair_top_acc_a: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		issue && op_kind == BTU_OP_PAIR_TEST && src_kind == BTU_SRC_ACC &&
		bit_address_operand == ACC_TOP_POS |=> !test_flag_two &&
		test_flag_one == $past(src_val[ACC_TOP_POS]))
		else $error("acc pair at top position wrong");
	pair_top_aux_a: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		issue && op_kind == BTU_OP_PAIR_TEST && src_kind == BTU_SRC_AUX &&
		bit_address_operand[3:0] == WORD_TOP_POS |=> !test_flag_two &&
		test_flag_one == $past(src_val[WORD_TOP_POS]))
		else $error("aux pair at top position wrong");
	pair_out_range_a: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		issue && op_kind == BTU_OP_PAIR_TEST && src_kind == BTU_SRC_ACC &&
		bit_address_operand > ACC_TOP_POS |=> !test_flag_one && !test_flag_two)
		else $error("out of range pair not zero");
	pair_acc_mid_a: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		issue && op_kind == BTU_OP_PAIR_TEST && src_kind == BTU_SRC_ACC &&
		bit_address_operand < ACC_TOP_POS |=>
		test_flag_one == $past(src_val[bit_address_operand]) &&
		test_flag_two == $past(src_val[bit_address_operand + 6'h01]))
		else $error("acc pair bits wrong");
	pair_aux_mid_a: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		issue && op_kind == BTU_OP_PAIR_TEST && src_kind == BTU_SRC_AUX &&
		bit_address_operand[3:0] != WORD_TOP_POS |=>
		test_flag_one == $past(src_val[bit_address_operand[3:0]]) &&
		test_flag_two == $past(src_val[bit_address_operand[3:0] + 4'h1]))
		else $error("aux pair bits wrong");
	reg_test_tf1_a: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		issue && op_kind == BTU_OP_REG_TEST && op_nibble == NIB_REG_TF1 &&
		src_kind == BTU_SRC_ACC && bit_address_operand <= ACC_TOP_POS |=>
		test_flag_one == $past(src_val[bit_address_operand]) &&
		$stable(test_flag_two))
		else $error("register test flag one wrong");
	reg_test_tf2_a: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		issue && op_kind == BTU_OP_REG_TEST && op_nibble == NIB_REG_TF2
		&& src_kind == BTU_SRC_AUX |=> test_flag_two ==
		$past(src_val[bit_address_operand[3:0]]) && $stable(test_flag_one))
		else $error("register test flag two wrong");
	reg_test_other_a: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		issue && op_kind == BTU_OP_REG_TEST && op_nibble != NIB_REG_TF1 &&
		op_nibble != NIB_REG_TF2 |=>
		$stable(test_flag_one) && $stable(test_flag_two))
		else $error("flags moved on unused nibble");
	mem_idx_reg_a: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		issue && op_kind == BTU_OP_MEM_TEST_REG |=>
		idx_q == $past(src_val[WORD_POS_W-1:0]))
		else $error("register bit index wrong");
	mem_idx_imm_a: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		issue && mem_op && op_kind != BTU_OP_MEM_TEST_REG |=>
		idx_q == $past(imm_bit_index))
		else $error("immediate bit index wrong");
	mem_test_span_a: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		issue && mem_op && !is_modify_op(op_kind) |=>
		mem_rd_req && mem_lock && !mem_wr_req ##1 !mem_lock && op_done)
		else $error("memory test sequence wrong");
	mem_flag_a: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		mem_rd_req && !flag_sel_q |=> test_flag_one ==
		$past(mem_rd_data[idx_q]) && $stable(test_flag_two))
		else $error("memory test flag one wrong");
	mem_flag_two_a: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		mem_rd_req && flag_sel_q |=> test_flag_two ==
		$past(mem_rd_data[idx_q]) && $stable(test_flag_one))
		else $error("memory test flag two wrong");
	mod_flag_sel_a: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		issue && is_modify_op(op_kind) |=>
		flag_sel_q == $past(op_nibble[NIB_MOD_FLAG_BIT]))
		else $error("modify form flag choice wrong");
	mem_lock_span_a: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		issue && (op_kind == BTU_OP_MEM_CLEAR || op_kind == BTU_OP_MEM_INVERT)
		|=> mem_rd_req && mem_lock ##1 mem_wr_req && mem_lock ##1 !mem_lock)
		else $error("modify access not locked");
	clear_bit_a: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		mem_wr_req && kind_q == BTU_OP_MEM_CLEAR |-> !mem_wr_data[idx_q])
		else $error("cleared bit not zero");
	clear_keep_a: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		mem_rd_req && kind_q == BTU_OP_MEM_CLEAR |=> mem_wr_data ==
		($past(mem_rd_data) & ~(WORD_W'(1) << idx_q)))
		else $error("cleared word wrong");
	invert_bit_a: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		mem_rd_req && kind_q == BTU_OP_MEM_INVERT |=> mem_wr_data ==
		($past(mem_rd_data) ^ (WORD_W'(1) << idx_q)))
		else $error("inverted word wrong");
	write_done_a: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		mem_wr_req |=> op_done && op_ready && !mem_lock)
		else $error("write-back did not close");
	repeat_ready_a: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		issue && !mem_op |=> op_ready && op_done)
		else $error("register test not repeatable");
endmodule : btu_top
`default_nettype wire

// *** btu_mem_model.sv ***
// Purpose: single-word data memory beside the bit test unit
// Assumes: read data valid while rd_req high, same cycle
// Notes: flags any access made without lock held
`timescale 1ns/1ps
`default_nettype none
module btu_mem_model
(
	input wire logic core_clk,
	input wire logic rd_req,
	input wire logic wr_req,
	input wire logic lock,
	input wire logic [15:0] wr_data,
	output logic [15:0] rd_data,
	input wire logic load,
	input wire logic [15:0] load_val,
	output logic [15:0] word_q,
	output logic lock_err
);
	// undriven bus shows the inverse, so stale data never passes
	assign rd_data = rd_req ? word_q : ~word_q;
	// plain always, since lock_err also takes a start value
	initial lock_err = 1'b0;
	always @(posedge core_clk)
	begin
		if (load)
			word_q <= load_val;
		else if (wr_req)
			word_q <= wr_data;
		if ((rd_req || wr_req) && !lock)
			lock_err <= 1'b1;
	end
endmodule : btu_mem_model
`default_nettype wire

// *** tb_top.sv ***
// Purpose: self-checking bench for btu_top
// Assumes: inputs driven 1 ns after the rising edge
// Notes: random operands from a fixed-seed lfsr
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import btu_pkg::*;
	logic core_clk, rst_n, op_valid, op_ready, mem_rd_req, mem_wr_req;
	logic mem_lock, test_flag_one, test_flag_two, op_done, load, lock_err;
	btu_op_t op_kind;
	btu_src_t src_kind;
	logic [3:0] op_nibble, imm_bit_index;
	logic [39:0] src_val;
	logic [5:0] bit_address_operand;
	logic [15:0] mem_addr, mem_rd_addr, mem_wr_data, mem_rd_data;
	logic [15:0] load_val, word_q;
	logic [31:0] rnd;
	logic ef1, ef2;
	int error_cnt, checks_done;
	btu_top uut (.core_clk(core_clk), .rst_n(rst_n), .op_valid(op_valid),
		.op_ready(op_ready), .op_kind(op_kind), .op_nibble(op_nibble),
		.src_kind(src_kind), .src_val(src_val),
		.bit_address_operand(bit_address_operand),
		.imm_bit_index(imm_bit_index), .mem_addr(mem_addr),
		.mem_rd_req(mem_rd_req), .mem_wr_req(mem_wr_req),
		.mem_lock(mem_lock), .mem_rd_addr(mem_rd_addr),
		.mem_wr_data(mem_wr_data), .mem_rd_data(mem_rd_data),
		.test_flag_one(test_flag_one), .test_flag_two(test_flag_two),
		.op_done(op_done));
	btu_mem_model mem (.core_clk(core_clk), .rd_req(mem_rd_req),
		.wr_req(mem_wr_req), .lock(mem_lock), .wr_data(mem_wr_data),
		.rd_data(mem_rd_data), .load(load), .load_val(load_val),
		.word_q(word_q), .lock_err(lock_err));
	// ==========================================
	// helpers
	function automatic logic [31:0] lfsr(logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	// returns {flag two, flag one}
	function automatic logic [1:0] exp_pair(btu_src_t k, logic [39:0] v,
		logic [5:0] p);
		int q;
		q = (k == BTU_SRC_ACC) ? int'(p) : int'(p[3:0]);
		if (q < ((k == BTU_SRC_ACC) ? 39 : 15))
			return {v[q + 1], v[q]};
		if (q < 40)
			return {1'b0, v[q]};
		return 2'b00;
	endfunction : exp_pair
	task automatic chk(logic [15:0] e, logic [15:0] g);
		checks_done++;
		if (g !== e)
		begin
			error_cnt++;
			$display("wrong value at %0t: exp %h got %h", $time, e, g);
		end
	endtask : chk
	task automatic end_sim();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_sim
	task automatic run_op(btu_op_t k, logic [3:0] nib, logic [15:0] w);
		int n;
		n = 0;
		op_kind = k;
		op_nibble = nib;
		op_valid = 1'b1;
		load = (k >= BTU_OP_MEM_TEST_REG);
		load_val = w;
		@(posedge core_clk);
		#1;
		if (k >= BTU_OP_MEM_TEST_REG)
		begin
			op_valid = 1'b0;
			load = 1'b0;
			chk(0, op_ready);
			while (op_done !== 1'b1 && n < 8)
			begin
				@(posedge core_clk);
				#1;
				n++;
			end
		end
		chk(1, op_done);
	endtask : run_op
	task automatic draw();
		rnd = lfsr(rnd);
		src_val = {rnd[7:0], rnd};
		rnd = lfsr(rnd);
		src_val[39:32] = src_val[39:32] ^ rnd[31:24];
		imm_bit_index = rnd[3:0];
		mem_addr = rnd[19:4];
	endtask : draw
	// ==========================================
	// clock, reset, watchdog
	initial
	begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	initial
	begin
		#200000;
		error_cnt++;
		end_sim();
	end
	// ==========================================
	// main sequence
	initial
	begin
		logic [1:0] ep;
		logic [15:0] w;
		int ix;
		{rst_n, op_valid, load, op_nibble, imm_bit_index} = '0;
		{src_val, bit_address_operand, mem_addr, load_val} = '0;
		op_kind = BTU_OP_REG_TEST;
		src_kind = BTU_SRC_ACC;
		rnd = 32'h8e08;
		{error_cnt, checks_done, ef1, ef2} = '0;
		repeat (6) @(posedge core_clk);
		#1;
		rst_n = 1'b1;
		chk(0, {test_flag_two, test_flag_one});
		// back to back, as under single-instruction repeat
		for (int i = 0; i < 120; i++)
		begin
			draw();
			src_kind = btu_src_t'(rnd[8]);
			bit_address_operand = 6'(rnd[15:10] % 40);
			ix = (src_kind == BTU_SRC_ACC) ? bit_address_operand
				: bit_address_operand[3:0];
			run_op(BTU_OP_REG_TEST, (i % 3 == 2) ? 4'h3 : 4'h8 + 4'(i % 3), 0);
			if (i % 3 == 0)
				ef1 = src_val[ix];
			if (i % 3 == 1)
				ef2 = src_val[ix];
			chk({ef2, ef1}, {test_flag_two, test_flag_one});
		end
		$display("test register single done");
		for (int i = 0; i < 120; i++)
		begin
			draw();
			src_kind = btu_src_t'((i < 4) ? 1'b0 : (i < 6) ? 1'b1 : rnd[8]);
			// acc 38, 39, 56, 57 and aux 14, 15 with stray high bits
			bit_address_operand = (i < 4) ? 6'h26 + 6'(i % 2) + 6'(i / 2 * 18)
				: (i < 6) ? 6'h3e + 6'(i % 2) : rnd[15:10];
			run_op(BTU_OP_PAIR_TEST, 4'h0, 0);
			ep = exp_pair(src_kind, src_val, bit_address_operand);
			{ef2, ef1} = ep;
			chk(ep, {test_flag_two, test_flag_one});
		end
		$display("test register pair done");
		for (int i = 0; i < 80; i++)
		begin
			draw();
			w = rnd[31:16];
			ix = (i % 4 == 0) ? src_val[3:0] : imm_bit_index;
			run_op(btu_op_t'(2 + i % 4), rnd[23:20], w);
			// clear and invert take the flag choice from nibble bit 1
			if ((i % 4 >= 2) ? rnd[21] : rnd[20])
				ef2 = w[ix];
			else
				ef1 = w[ix];
			chk({ef2, ef1}, {test_flag_two, test_flag_one});
			chk(mem_addr, mem_rd_addr);
			if (i % 4 == 2)
				w[ix] = 1'b0;
			if (i % 4 == 3)
				w[ix] = ~w[ix];
			chk(w, word_q);
		end
		chk(0, lock_err);
		$display("test memory forms done");
		end_sim();
	end
endmodule : tb_top
`default_nettype wire
